// ---- logic/cmt_pkg.sv ----
package cmt_pkg;
    // Reference clock
    localparam int CLK_PERIOD_NS = 40;

    // Nominal analog intervals, in nanoseconds
    localparam int RW_DELAY_NS = 1;
    localparam int RW_WIDTH_NS = 1200;
    localparam int GAP_DELAY_NS = 280;
    localparam int GAP_WIDTH_NS = 360;
    localparam int EDGE_WIDTH_NS = 150;

    // Intervals with no printed figure, in cycles
    localparam int ASW_DELAY_CYC_DEF = 1;
    localparam int ASW_WINDOW_CYC_DEF = 8;
    localparam int INH_EXT_CYC_DEF = 4;
    localparam int STB_DELAY_CYC_DEF = 10;
    localparam int STB_WIDTH_CYC_DEF = 5;

    localparam int WORD_W_DEF = 49;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // Least time: round up to whole cycles, never below one cycle
    function automatic int cmt_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RW_DELAY_CYC = cmt_cyc(RW_DELAY_NS);
    localparam int RW_WIDTH_CYC = cmt_cyc(RW_WIDTH_NS);
    localparam int GAP_DELAY_CYC = cmt_cyc(GAP_DELAY_NS);
    localparam int GAP_WIDTH_CYC = cmt_cyc(GAP_WIDTH_NS);
    localparam int EDGE_WIDTH_CYC = cmt_cyc(EDGE_WIDTH_NS);

    // Down-counter step, saturating at zero
    function automatic logic [CNT_W-1:0] cmt_step(input logic [CNT_W-1:0] c);
        return (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
    endfunction

    // Output window of a delay-then-width one-shot
    function automatic logic cmt_win(input logic [CNT_W-1:0] c,
                                     input logic [CNT_W-1:0] wid);
        return (c != CNT_ZERO) && (c <= wid);
    endfunction

    typedef enum logic [1:0] {
        CMT_ASW_IDLE,
        CMT_ASW_DELAY,
        CMT_ASW_WINDOW,
        CMT_ASW_HELD
    } cmt_asw_e;

    // Timing levels and pulses of one memory cycle
    typedef struct packed {
        logic address_switch_level;
        logic read_current_pulse;
        logic rw_gap_pulse;
        logic inhibit_timing_level;
        logic write_current_pulse;
        logic register_strobe;
    } cmt_timing_s;
endpackage

// ---- logic/cmt_edge_pulse_shaper.sv ----
`timescale 1ns/1ps
module cmt_edge_pulse_shaper #(
    parameter int WIDTH_CYC = cmt_pkg::EDGE_WIDTH_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Level in, pulse out
    input wire logic trig_in,
    output logic pulse_ff
);
    import cmt_pkg::*;

    localparam logic [CNT_W-1:0] WID = CNT_W'(WIDTH_CYC);

    logic [CNT_W-1:0] cnt_ff;
    logic prev_ff;
    logic fire;

    initial begin
        if (WIDTH_CYC < 1 || WIDTH_CYC > 255) begin
            $error("edge shaper width out of range");
        end
    end

    // The input is treated as held true while the pulse runs
    assign fire = trig_in && !prev_ff && (cnt_ff == CNT_ZERO);

    // Reset prev high so an input already true at release gives no pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= trig_in || (cnt_ff != CNT_ZERO);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= CNT_ZERO;
            pulse_ff <= 1'b0;
        end else if (fire) begin
            cnt_ff <= WID;
            pulse_ff <= 1'b1;
        end else begin
            cnt_ff <= cmt_step(cnt_ff);
            pulse_ff <= (cnt_ff > CNT_ONE);
        end
    end

    a_shaper_width: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(pulse_ff) |-> $past(pulse_ff, WIDTH_CYC) &&
        !$past(pulse_ff, WIDTH_CYC + 1))
        else $error("shaper pulse width wrong");
    a_shaper_rise: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(pulse_ff) |-> $past(trig_in))
        else $error("shaper pulse without rising input");
endmodule

// ---- logic/cmt_core_cycle_timing.sv ----
`timescale 1ns/1ps
module cmt_core_cycle_timing #(
    parameter int WORD_W = cmt_pkg::WORD_W_DEF,
    parameter int ASW_DELAY_CYC = cmt_pkg::ASW_DELAY_CYC_DEF,
    parameter int ASW_WINDOW_CYC = cmt_pkg::ASW_WINDOW_CYC_DEF,
    parameter int INH_EXT_CYC = cmt_pkg::INH_EXT_CYC_DEF,
    parameter int STB_DELAY_CYC = cmt_pkg::STB_DELAY_CYC_DEF,
    parameter int STB_WIDTH_CYC = cmt_pkg::STB_WIDTH_CYC_DEF,
    parameter int RW_DELAY_CYC = cmt_pkg::RW_DELAY_CYC,
    parameter int RW_WIDTH_CYC = cmt_pkg::RW_WIDTH_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // From the memory exchange
    input wire logic cycle_start,
    input wire logic [WORD_W-1:0] info_reg_bits,
    input wire logic mem_osc,
    // Timing outputs
    output cmt_pkg::cmt_timing_s timing_ff,
    output logic [WORD_W-1:0] inhibit_drive_ff,
    output logic cycle_clear,
    output logic clock_pulse,
    output logic hold_late_err_ff
);
    import cmt_pkg::*;

    localparam logic [CNT_W-1:0] ASW_DLY = CNT_W'(ASW_DELAY_CYC);
    localparam logic [CNT_W-1:0] ASW_WIN = CNT_W'(ASW_WINDOW_CYC);
    localparam logic [CNT_W-1:0] INH_EXT = CNT_W'(INH_EXT_CYC);
    localparam logic [CNT_W-1:0] RW_WID = CNT_W'(RW_WIDTH_CYC);
    localparam logic [CNT_W-1:0] RW_LOAD = CNT_W'(RW_DELAY_CYC + RW_WIDTH_CYC);
    localparam logic [CNT_W-1:0] GAP_WID = CNT_W'(GAP_WIDTH_CYC);
    localparam logic [CNT_W-1:0] GAP_LOAD =
        CNT_W'(GAP_DELAY_CYC + GAP_WIDTH_CYC);
    localparam logic [CNT_W-1:0] STB_WID = CNT_W'(STB_WIDTH_CYC);
    localparam logic [CNT_W-1:0] STB_LOAD =
        CNT_W'(STB_DELAY_CYC + STB_WIDTH_CYC);

    initial begin
        if (ASW_DELAY_CYC < 1 || ASW_WINDOW_CYC < 1 || INH_EXT_CYC < 1 ||
            STB_DELAY_CYC < 1 || STB_WIDTH_CYC < 1 || RW_DELAY_CYC < 1 ||
            RW_WIDTH_CYC < 1 || WORD_W < 1) begin
            $error("timing parameter below one");
        end
        if (ASW_DELAY_CYC > 255 || ASW_WINDOW_CYC > 255 ||
            INH_EXT_CYC > 255 || STB_DELAY_CYC + STB_WIDTH_CYC > 255 ||
            RW_DELAY_CYC + RW_WIDTH_CYC > 255 ||
            GAP_DELAY_CYC + GAP_WIDTH_CYC > 255) begin
            $error("timing parameter exceeds counter");
        end
    end

    cmt_asw_e asw_state_ff;
    logic [CNT_W-1:0] asw_cnt_ff;
    logic [CNT_W-1:0] rd_cnt_ff;
    logic [CNT_W-1:0] wr_cnt_ff;
    logic [CNT_W-1:0] gap_cnt_ff;
    logic [CNT_W-1:0] ext_cnt_ff;
    logic [CNT_W-1:0] stb_cnt_ff;
    logic [CNT_W-1:0] nxt_rd_cnt;
    logic [CNT_W-1:0] nxt_wr_cnt;
    logic [CNT_W-1:0] nxt_gap_cnt;
    logic start_prev_ff;
    logic rd_arm_ff;
    logic stb_arm_ff;
    logic start_rise;
    logic asw_take;
    logic asw_hold;
    logic rd_fire;
    logic wr_fire;
    logic nxt_rd;
    logic nxt_wr;
    logic nxt_gap;
    logic nxt_inh;
    logic rd_fall;

    assign start_rise = cycle_start && !start_prev_ff;
    // Only a start taken while idle may arm the once-per-cycle gates
    assign asw_take = start_rise && (asw_state_ff == CMT_ASW_IDLE);
    // Gap delay counter bridges the dead time between read and gap
    assign asw_hold = timing_ff.read_current_pulse | timing_ff.rw_gap_pulse |
                      (gap_cnt_ff != CNT_ZERO) |
                      timing_ff.write_current_pulse |
                      timing_ff.inhibit_timing_level;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_prev_ff <= 1'b0;
        end else begin
            start_prev_ff <= cycle_start;
        end
    end

    // Address-switch level: delay, start-hold window, then held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            asw_state_ff <= CMT_ASW_IDLE;
            asw_cnt_ff <= CNT_ZERO;
            timing_ff.address_switch_level <= 1'b0;
            hold_late_err_ff <= 1'b0;
        end else begin
            case (asw_state_ff)
                CMT_ASW_IDLE: begin
                    if (start_rise) begin
                        asw_state_ff <= CMT_ASW_DELAY;
                        asw_cnt_ff <= ASW_DLY;
                        hold_late_err_ff <= 1'b0;
                    end
                end
                CMT_ASW_DELAY: begin
                    asw_cnt_ff <= cmt_step(asw_cnt_ff);
                    if (asw_cnt_ff == CNT_ONE) begin
                        asw_state_ff <= CMT_ASW_WINDOW;
                        asw_cnt_ff <= ASW_WIN;
                        timing_ff.address_switch_level <= 1'b1;
                    end
                end
                CMT_ASW_WINDOW: begin
                    asw_cnt_ff <= cmt_step(asw_cnt_ff);
                    if (asw_hold) begin
                        asw_state_ff <= CMT_ASW_HELD;
                    end else if (asw_cnt_ff == CNT_ONE) begin
                        // Hold came too late: output collapses
                        asw_state_ff <= CMT_ASW_IDLE;
                        timing_ff.address_switch_level <= 1'b0;
                        hold_late_err_ff <= 1'b1;
                    end
                end
                CMT_ASW_HELD: begin
                    if (!cycle_start && !asw_hold) begin
                        asw_state_ff <= CMT_ASW_IDLE;
                        timing_ff.address_switch_level <= 1'b0;
                    end
                end
                default: begin
                    asw_state_ff <= CMT_ASW_IDLE;
                    timing_ff.address_switch_level <= 1'b0;
                end
            endcase
        end
    end

    // Read current: second gate input is armed once per cycle
    assign rd_fire = timing_ff.address_switch_level && rd_arm_ff &&
                     (rd_cnt_ff == CNT_ZERO);
    assign nxt_rd_cnt = rd_fire ? RW_LOAD : cmt_step(rd_cnt_ff);
    assign nxt_rd = cmt_win(nxt_rd_cnt, RW_WID) &&
                    timing_ff.address_switch_level;
    assign rd_fall = timing_ff.read_current_pulse && !nxt_rd;

    always_ff @(posedge clk_sys) begin
        if (rst || cycle_clear) begin
            rd_arm_ff <= 1'b0;
        end else if (asw_take) begin
            rd_arm_ff <= 1'b1;
        end else if (rd_fire) begin
            rd_arm_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_cnt_ff <= CNT_ZERO;
            timing_ff.read_current_pulse <= 1'b0;
        end else begin
            rd_cnt_ff <= nxt_rd ? nxt_rd_cnt :
                         (cmt_win(nxt_rd_cnt, RW_WID) ? CNT_ZERO : nxt_rd_cnt);
            timing_ff.read_current_pulse <= nxt_rd;
        end
    end

    // Gap: triggered on read fall, width fixed regardless of input
    assign nxt_gap_cnt = rd_fall ? GAP_LOAD : cmt_step(gap_cnt_ff);
    assign nxt_gap = cmt_win(nxt_gap_cnt, GAP_WID);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_cnt_ff <= CNT_ZERO;
            timing_ff.rw_gap_pulse <= 1'b0;
        end else begin
            gap_cnt_ff <= nxt_gap_cnt;
            timing_ff.rw_gap_pulse <= nxt_gap;
        end
    end

    // Write current fires on inhibit rise; only one gate input used
    assign wr_fire = timing_ff.inhibit_timing_level &&
                     timing_ff.rw_gap_pulse &&
                     (wr_cnt_ff == CNT_ZERO) &&
                     !timing_ff.write_current_pulse &&
                     (gap_cnt_ff == GAP_WID);
    assign nxt_wr_cnt = wr_fire ? RW_LOAD : cmt_step(wr_cnt_ff);
    assign nxt_wr = cmt_win(nxt_wr_cnt, RW_WID) &&
                    timing_ff.inhibit_timing_level;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_cnt_ff <= CNT_ZERO;
            timing_ff.write_current_pulse <= 1'b0;
        end else begin
            wr_cnt_ff <= nxt_wr ? nxt_wr_cnt :
                         (cmt_win(nxt_wr_cnt, RW_WID) ? CNT_ZERO : nxt_wr_cnt);
            timing_ff.write_current_pulse <= nxt_wr;
        end
    end

    // Inhibit uses next-state of gap so both rise on the same edge
    assign nxt_inh = nxt_gap || nxt_wr ||
                     (ext_cnt_ff != CNT_ZERO);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_cnt_ff <= CNT_ZERO;
            timing_ff.inhibit_timing_level <= 1'b0;
        end else begin
            ext_cnt_ff <= (nxt_gap || nxt_wr) ? INH_EXT :
                          cmt_step(ext_cnt_ff);
            timing_ff.inhibit_timing_level <= nxt_inh;
        end
    end

    // Per-bit drivers gated by the same next-state for no skew
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inhibit_drive_ff <= '0;
        end else begin
            inhibit_drive_ff <= ~info_reg_bits & {WORD_W{nxt_inh}};
        end
    end

    // Strobe: one per cycle from read rise
    always_ff @(posedge clk_sys) begin
        if (rst || cycle_clear) begin
            stb_arm_ff <= 1'b0;
        end else if (asw_take) begin
            stb_arm_ff <= 1'b1;
        end else if (nxt_rd && !timing_ff.read_current_pulse) begin
            stb_arm_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stb_cnt_ff <= CNT_ZERO;
            timing_ff.register_strobe <= 1'b0;
        end else if (nxt_rd && !timing_ff.read_current_pulse && stb_arm_ff) begin
            stb_cnt_ff <= STB_LOAD;
            timing_ff.register_strobe <= 1'b0;
        end else begin
            stb_cnt_ff <= cmt_step(stb_cnt_ff);
            timing_ff.register_strobe <=
                cmt_win(cmt_step(stb_cnt_ff), STB_WID);
        end
    end

    // End-of-cycle clear on fall of the address-switch level
    cmt_edge_pulse_shaper #(.WIDTH_CYC(EDGE_WIDTH_CYC)) u_clear (
        .clk_sys(clk_sys),
        .rst(rst),
        .trig_in(!timing_ff.address_switch_level),
        .pulse_ff(cycle_clear)
    );

    // Memory oscillator to fixed-width clock pulses
    cmt_edge_pulse_shaper #(.WIDTH_CYC(EDGE_WIDTH_CYC)) u_osc (
        .clk_sys(clk_sys),
        .rst(rst),
        .trig_in(mem_osc),
        .pulse_ff(clock_pulse)
    );

    a_asw_delay: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timing_ff.address_switch_level) |->
        $past(asw_take, ASW_DELAY_CYC + 1))
        else $error("address switch delay wrong");
    a_asw_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ($fell(timing_ff.address_switch_level) && !hold_late_err_ff) |->
        $past(!cycle_start && !asw_hold))
        else $error("address switch dropped while held");
    a_asw_window: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(hold_late_err_ff) |-> $fell(timing_ff.address_switch_level))
        else $error("late hold did not collapse level");
    a_asw_span: assert property (@(posedge clk_sys) disable iff (rst)
        (timing_ff.write_current_pulse || timing_ff.read_current_pulse) |->
        timing_ff.address_switch_level)
        else $error("current pulse outside address switch level");
    a_inh_with_gap: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timing_ff.rw_gap_pulse) |-> timing_ff.inhibit_timing_level)
        else $error("inhibit late on gap");
    a_inh_covers: assert property (@(posedge clk_sys) disable iff (rst)
        (timing_ff.rw_gap_pulse || timing_ff.write_current_pulse) |->
        timing_ff.inhibit_timing_level)
        else $error("inhibit dropped while gap or write");
    a_inh_extend: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(timing_ff.inhibit_timing_level) |->
        $past(timing_ff.write_current_pulse, INH_EXT_CYC + 1) &&
        !$past(timing_ff.write_current_pulse, INH_EXT_CYC))
        else $error("inhibit extension short");
    a_gap_delay: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(timing_ff.read_current_pulse) |->
        !timing_ff.rw_gap_pulse [*7] ##1 timing_ff.rw_gap_pulse [*8]
        ##1 timing_ff.rw_gap_pulse ##1 !timing_ff.rw_gap_pulse)
        else $error("gap delay or width wrong");
    a_wr_after_inh: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timing_ff.inhibit_timing_level) |->
        ##[1:3] timing_ff.write_current_pulse)
        else $error("write pulse not fired by inhibit");
    a_rd_once: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timing_ff.read_current_pulse) |-> !rd_arm_ff)
        else $error("read generator still armed");
    a_rd_early_end: assert property (@(posedge clk_sys) disable iff (rst)
        !timing_ff.address_switch_level |-> ##1
        !timing_ff.read_current_pulse)
        else $error("read pulse outlived its trigger");
    a_stb_delay: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timing_ff.register_strobe) |->
        $past(timing_ff.read_current_pulse, STB_DELAY_CYC) &&
        !$past(timing_ff.read_current_pulse, STB_DELAY_CYC + 1))
        else $error("strobe delay wrong");
    a_stb_width: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(timing_ff.register_strobe) |->
        $past(timing_ff.register_strobe, STB_WIDTH_CYC) &&
        !$past(timing_ff.register_strobe, STB_WIDTH_CYC + 1))
        else $error("strobe width wrong");
    a_inh_driver: assert property (@(posedge clk_sys) disable iff (rst)
        (inhibit_drive_ff != '0) |-> timing_ff.inhibit_timing_level)
        else $error("inhibit driver without inhibit level");
endmodule

// ---- sim/cmt_exchange_model.sv ----
`timescale 1ns/1ps
module cmt_exchange_model #(
    parameter int WORD_W = cmt_pkg::WORD_W_DEF
) (
    // Clock
    input wire logic clk_sys,
    // Cycle status seen from the timing block
    input wire logic busy,
    // Requests to the timing block
    output logic cycle_start,
    output logic [WORD_W-1:0] info_reg_bits
);
    import cmt_pkg::*;

    initial begin
        cycle_start = 1'h0;
        info_reg_bits = '0;
    end

    // Start level only; the block makes its own hold from its pulses
    task automatic pulse(input int hold, input logic [WORD_W-1:0] bits);
        @(negedge clk_sys);
        info_reg_bits = bits;
        cycle_start = 1'h1;
        repeat (hold) @(negedge clk_sys);
        cycle_start = 1'h0;
    endtask

    // A fresh start once level and clear pulse are both gone, or after 200 cycles at most
    task automatic start_cycle(input int hold,
                               input logic [WORD_W-1:0] bits);
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        pulse(hold, bits);
    endtask
endmodule

// ---- sim/cmt_core_cycle_timing_tb_top.sv ----
`timescale 1ns/1ps
module cmt_core_cycle_timing_tb_top;
    import cmt_pkg::*;
    localparam int W = WORD_W_DEF;
    localparam int T_MAX = 1500;
    localparam logic [W-1:0] PAT = 49'h0_AAAA_5555_F0F0;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic mem_osc = 1'h0;
    logic cycle_start;
    logic [W-1:0] info_reg_bits;
    cmt_timing_s timing_ff;
    logic [W-1:0] inhibit_drive_ff;
    logic cycle_clear;
    logic clock_pulse;
    logic hold_late_err_ff;
    logic late_err;
    int n_errors = 0;
    int num_checks = 0;
    int t = 0;
    int rise[9];
    int fall[9];
    int nrise[9];
    logic [8:0] sig_q = '0;
    logic [W-1:0] drv_cap;

    always #20 clk_sys = ~clk_sys;

    cmt_core_cycle_timing dut_u (
        .clk_sys(clk_sys), .rst(rst), .cycle_start(cycle_start),
        .info_reg_bits(info_reg_bits), .mem_osc(mem_osc),
        .timing_ff(timing_ff), .inhibit_drive_ff(inhibit_drive_ff),
        .cycle_clear(cycle_clear), .clock_pulse(clock_pulse),
        .hold_late_err_ff(hold_late_err_ff));

    // Read delay beyond the hold window, so the level must collapse
    cmt_core_cycle_timing #(.RW_DELAY_CYC(12)) dut_late_u (
        .clk_sys(clk_sys), .rst(rst), .cycle_start(cycle_start),
        .info_reg_bits(info_reg_bits), .mem_osc(mem_osc),
        .timing_ff(), .inhibit_drive_ff(), .cycle_clear(),
        .clock_pulse(), .hold_late_err_ff(late_err));

    cmt_exchange_model xchg_u (
        .clk_sys(clk_sys),
        .busy(timing_ff.address_switch_level | cycle_clear),
        .cycle_start(cycle_start), .info_reg_bits(info_reg_bits));

    // Sampled just after the edge, once registered outputs have settled
    always @(posedge clk_sys) begin
        logic [8:0] s;
        #1;
        s = {cycle_start, clock_pulse, cycle_clear, timing_ff};
        t++;
        for (int i = 0; i < 9; i++) begin
            if (s[i] === 1'h1 && sig_q[i] !== 1'h1) begin
                rise[i] = t;
                nrise[i]++;
            end
            if (s[i] !== 1'h1 && sig_q[i] === 1'h1) begin
                fall[i] = t;
            end
        end
        if (s[2] === 1'h1 && sig_q[2] !== 1'h1) begin
            drv_cap = inhibit_drive_ff;
        end
        sig_q = s;
        if (t == T_MAX) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [W-1:0] exp,
                       input logic [W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi,
                           input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    task automatic clear_rec();
        rise = '{default: 0};
        fall = '{default: 0};
        nrise = '{default: 0};
    endtask

    task automatic test_cycle(input int hold, input logic [W-1:0] bits);
        int e;
        clear_rec();
        xchg_u.start_cycle(hold, bits);
        repeat (120) @(negedge clk_sys);
        e = (fall[2] > fall[8]) ? fall[2] : fall[8];
        chk_rng("asw delay", 1, ASW_DELAY_CYC_DEF + 2, rise[5] - rise[8]);
        // One extra cycle for the read gate to see the level
        chk_rng("read delay", RW_DELAY_CYC + 1, RW_DELAY_CYC + 1,
                rise[4] - rise[5]);
        chk_rng("read width", RW_WIDTH_CYC, RW_WIDTH_CYC, fall[4] - rise[4]);
        chk_rng("gap delay", GAP_DELAY_CYC, GAP_DELAY_CYC, rise[3] - fall[4]);
        chk_rng("gap width", GAP_WIDTH_CYC, GAP_WIDTH_CYC, fall[3] - rise[3]);
        chk_rng("inhibit rise", rise[3], rise[3], rise[2]);
        chk_rng("write start", rise[2] + 1, rise[2] + 3, rise[1]);
        chk_rng("write width", RW_WIDTH_CYC, RW_WIDTH_CYC, fall[1] - rise[1]);
        chk_rng("inhibit ext", INH_EXT_CYC_DEF, INH_EXT_CYC_DEF,
                fall[2] - fall[1]);
        chk_rng("strobe delay", STB_DELAY_CYC_DEF, STB_DELAY_CYC_DEF,
                rise[0] - rise[4]);
        chk_rng("strobe width", STB_WIDTH_CYC_DEF, STB_WIDTH_CYC_DEF,
                fall[0] - rise[0]);
        chk_rng("strobe count", 1, 1, nrise[0]);
        chk_rng("asw end", e, e + 1, fall[5]);
        chk_rng("clear start", fall[5], fall[5] + 1, rise[6]);
        chk_rng("clear width", EDGE_WIDTH_CYC, EDGE_WIDTH_CYC,
                fall[6] - rise[6]);
        chk("inhibit drive", ~bits, drv_cap);
        chk("drive idle", '0, inhibit_drive_ff);
    endtask

    // Second start while the cycle runs must not restart it
    task automatic test_retrigger();
        clear_rec();
        xchg_u.start_cycle(2, '1);
        repeat (15) @(negedge clk_sys);
        xchg_u.pulse(2, '1);
        repeat (130) @(negedge clk_sys);
        chk_rng("asw count", 1, 1, nrise[5]);
        chk_rng("read count", 1, 1, nrise[4]);
        chk_rng("strobe count", 1, 1, nrise[0]);
        chk("drive ones", '0, drv_cap);
    endtask

    task automatic test_osc();
        clear_rec();
        mem_osc = 1'h1;
        @(negedge clk_sys);
        mem_osc = 1'h0;
        @(negedge clk_sys);
        mem_osc = 1'h1;
        repeat (10) @(negedge clk_sys);
        mem_osc = 1'h0;
        repeat (10) @(negedge clk_sys);
        chk_rng("osc pulses", 1, 1, nrise[7]);
        chk_rng("osc width", EDGE_WIDTH_CYC, EDGE_WIDTH_CYC,
                fall[7] - rise[7]);
        mem_osc = 1'h1;
        repeat (8) @(negedge clk_sys);
        chk_rng("osc second", 2, 2, nrise[7]);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'h0;
        @(negedge clk_sys);
        chk("reset timing", '0, timing_ff);
        test_cycle(2, PAT);
        chk("late hold", 1'h1, late_err);
        chk("own hold", 1'h0, hold_late_err_ff);
        test_cycle(100, ~PAT);
        test_retrigger();
        test_osc();
        print_verdict();
    end
endmodule
